// *** button_level_consts.svh ***
`ifndef BUTTON_LEVEL_CONSTS_SVH
`define BUTTON_LEVEL_CONSTS_SVH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_IDLE 12'h004
`define OFS_MAP 12'h008
`define OFS_STATUS 12'h00c
`define OFS_LEVEL_BASE 12'h010
`define OFS_LEVEL_LAST 12'h02c

// control fields
`define CTRL_MODE_LSB 0
`define CTRL_P64_BIT 2
`define CTRL_BUZZ_LSB 3
`define CTRL_BUZZ_RET_BIT 5
`define CTRL_SW_IDLE_BIT 6
`define CTRL_WIDTH 7

// status fields
`define STAT_REP_LSB 8
`define STAT_VALID_BIT 12
`define STAT_HOLD_BIT 13

// reset values
`define CTRL_RESET 7'h01
`define IDLE_RESET 16'h0000
`define MAP_RESET 16'h5555

// pwm period and level limits
`define PERIOD_SHORT_LAST 8'h3f
`define LEVEL_SHORT_MAX 8'h3f

`endif

// *** button_level_pkg.sv ***
package button_level_pkg;

  typedef enum logic [1:0] {
    REPORT_ALL = 2'b00,
    REPORT_FIRST = 2'b01,
    REPORT_STRONG = 2'b10
  } report_mode_type;

  typedef enum logic [1:0] {
    BUZZ_NONE = 2'b00,
    BUZZ_LOW = 2'b01,
    BUZZ_HIGH = 2'b10,
    BUZZ_IDLE = 2'b11
  } buzz_force_type;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_FETCH = 2'b01,
    APB_DONE = 2'b10
  } apb_state_type;

endpackage

// *** button_level_pwm_reporter.sv ***
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "button_level_consts.svh"

module button_level_pwm_reporter #(
  parameter int BUTTONS = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // sensing results, same clock
  input wire logic scan_tick_i,
  input wire logic [BUTTONS-1:0] touch_i,
  input wire logic [8*BUTTONS-1:0] strength_i,
  input wire logic buzzer_active_i,
  // level pins
  output logic general_pin_seven_o,
  output logic general_pin_seven_oe_o,
  output logic general_pin_six_o,
  output logic general_pin_six_oe_o
);
  import button_level_pkg::*;

  function automatic logic [2:0] pick_lowest(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] strength_of(input logic [63:0] s,
                                             input logic [2:0] i);
    return s[{i, 3'h0} +: 8];
  endfunction

  function automatic logic [2:0] pick_strongest(input logic [7:0] m,
                                                input logic [63:0] s);
    logic [2:0] r;
    logic [7:0] best;
    logic found;
    r = 3'h0;
    best = 8'h00;
    found = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (m[i] && (!found || s[i*8 +: 8] > best)) begin
        r = 3'(i);
        best = s[i*8 +: 8];
        found = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [8:0] level_width(input logic [7:0] idx,
                                             input logic p64);
    logic [7:0] c;
    c = (p64 && idx > `LEVEL_SHORT_MAX) ? `LEVEL_SHORT_MAX : idx;
    return (c == 8'h00) ? 9'h000 : ({1'b0, c} + 9'h001);
  endfunction

  // configuration and state
  logic [`CTRL_WIDTH-1:0] ctrl_ff;
  logic [15:0] idle_ff;
  logic [15:0] map_ff;
  logic [2:0] rep_idx_ff;
  logic rep_valid_ff;
  logic [7:0] prev_touch_ff;
  logic [7:0] bus_status_ff;
  logic idle_hold_ff;
  logic buzz_seen_ff;
  logic [7:0] cnt_ff;
  logic [1:0] pin_ff;
  apb_state_type apb_state_ff;
  logic [31:0] prdata_ff;
  logic [7:0] level_q;
  logic [7:0] bus_level_q;

  // apb decode
  wire access_w = psel_i & penable_i;
  wire wr_w = access_w & pwrite_i;
  wire sel_ctrl = paddr_i == `OFS_CTRL;
  wire sel_idle = paddr_i == `OFS_IDLE;
  wire sel_map = paddr_i == `OFS_MAP;
  wire sel_status = paddr_i == `OFS_STATUS;
  wire sel_level = paddr_i >= `OFS_LEVEL_BASE &&
                   paddr_i <= `OFS_LEVEL_LAST && paddr_i[1:0] == 2'b00;
  wire mapped_w = sel_ctrl | sel_idle | sel_map | sel_status | sel_level;
  // level slot n sits at the level base plus four times n
  wire [2:0] lvl_addr = {~paddr_i[4], paddr_i[3:2]};

  assign pready_o = access_w & (pwrite_i | apb_state_ff == APB_DONE);
  assign pslverr_o = pready_o & ~mapped_w;
  assign prdata_o = prdata_ff;

  wire [`CTRL_WIDTH-1:0] nxt_ctrl = (wr_w & sel_ctrl) ?
                                    pwdata_i[`CTRL_WIDTH-1:0] : ctrl_ff;
  wire [15:0] nxt_idle = (wr_w & sel_idle) ? pwdata_i[15:0] : idle_ff;
  // per-button channel map
  // map bits writable
  wire [15:0] nxt_map = (wr_w & sel_map) ? pwdata_i[15:0] : map_ff;

  // control fields
  wire [1:0] mode_bits = ctrl_ff[`CTRL_MODE_LSB +: 2];
  wire p64_w = ctrl_ff[`CTRL_P64_BIT];
  wire [1:0] buzz_bits = ctrl_ff[`CTRL_BUZZ_LSB +: 2];
  wire buzz_ret_w = ctrl_ff[`CTRL_BUZZ_RET_BIT];
  wire sw_idle_w = ctrl_ff[`CTRL_SW_IDLE_BIT];
  report_mode_type mode_w;
  buzz_force_type buzz_w;
  assign mode_w = report_mode_type'(mode_bits);
  assign buzz_w = buzz_force_type'(buzz_bits);

  wire [31:0] status_word = {18'h00000, idle_hold_ff, rep_valid_ff,
                             1'b0, rep_idx_ff, bus_status_ff};
  wire [31:0] rd_word = sel_ctrl ? {25'h0000000, ctrl_ff} :
                        sel_idle ? {16'h0000, idle_ff} :
                        sel_map ? {16'h0000, map_ff} :
                        sel_status ? status_word :
                        sel_level ? {24'h000000, bus_level_q} :
                        32'h00000000;

  apb_state_type nxt_apb_state;
  always_comb begin
    nxt_apb_state = apb_state_ff;
    case (apb_state_ff)
      APB_IDLE: begin
        if (access_w && !pwrite_i) begin
          nxt_apb_state = APB_FETCH;
        end
      end
      APB_FETCH: nxt_apb_state = APB_DONE;
      APB_DONE: nxt_apb_state = APB_IDLE;
      default: nxt_apb_state = APB_IDLE;
    endcase
  end
  wire [31:0] nxt_prdata = (apb_state_ff == APB_FETCH) ? rd_word :
                           prdata_ff;

  level_store #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_levels (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .we_i(wr_w & sel_level),
    .waddr_i(lvl_addr),
    .wdata_i(pwdata_i[7:0]),
    .raddr_a_i(rep_idx_ff),
    .rdata_a_o(level_q),
    .raddr_b_i(lvl_addr),
    .rdata_b_o(bus_level_q)
  );

  // button selection
  wire [7:0] touched_w = touch_i;
  wire any_touch = |touched_w;
  wire rep_alive = rep_valid_ff & touched_w[rep_idx_ff];
  wire [7:0] new_mask = touched_w & ~prev_touch_ff;
  wire [2:0] low_idx = pick_lowest(touched_w);
  wire [2:0] strong_idx = pick_strongest(touched_w, strength_i);
  wire [2:0] new_idx = pick_strongest(new_mask, strength_i);
  wire upgrade_w = (|new_mask) && strength_of(strength_i, new_idx) >
                   strength_of(strength_i, rep_idx_ff);
  wire [2:0] strong_sel = rep_alive ? (upgrade_w ? new_idx : rep_idx_ff) :
                          strong_idx;
  wire [2:0] first_sel = rep_alive ? rep_idx_ff : low_idx;
  wire [2:0] sel_idx = (mode_w == REPORT_STRONG) ? strong_sel : first_sel;
  wire switched_w = rep_valid_ff & any_touch & (sel_idx != rep_idx_ff);

  wire nxt_rep_valid = scan_tick_i ? any_touch : rep_valid_ff;
  wire [2:0] nxt_rep_idx = (scan_tick_i && any_touch) ? sel_idx :
                           rep_idx_ff;
  wire [7:0] nxt_prev_touch = scan_tick_i ? touched_w : prev_touch_ff;
  wire [7:0] rep_onehot = any_touch ? (8'h01 << sel_idx) : 8'h00;
  wire [7:0] nxt_bus_status = !scan_tick_i ? bus_status_ff :
                              (mode_w == REPORT_ALL) ? touched_w :
                              rep_onehot;

  // buzzer seen during the period; a new buzz beats the clear
  wire nxt_buzz_seen = buzzer_active_i | (buzz_seen_ff & ~scan_tick_i);
  wire hold_cause = (sw_idle_w & switched_w) |
                    (buzz_ret_w & buzz_seen_ff & ~buzzer_active_i);
  wire nxt_idle_hold = scan_tick_i ? hold_cause : idle_hold_ff;

  // period 256 or 64
  // a count past the short end wraps at once, no dead stretch
  wire [7:0] nxt_cnt = (p64_w && cnt_ff >= `PERIOD_SHORT_LAST) ? 8'h00 :
                       cnt_ff + 8'h01;

  wire buzz_force_on = buzzer_active_i & (buzz_w != BUZZ_NONE);
  wire [1:0] rep_map = map_ff[{rep_idx_ff, 1'b0} +: 2];
  logic [15:0] ch_idx_w;
  logic [17:0] ch_width_w;
  logic [17:0] ch_idle_width_w;
  logic [1:0] nxt_pin;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      wire active = rep_valid_ff & rep_map[ch] & ~idle_hold_ff;
      assign ch_idx_w[ch*8 +: 8] = active ? level_q : idle_ff[ch*8 +: 8];
      assign ch_width_w[ch*9 +: 9] = level_width(ch_idx_w[ch*8 +: 8],
                                                 p64_w);
      assign ch_idle_width_w[ch*9 +: 9] = level_width(idle_ff[ch*8 +: 8],
                                                      p64_w);
      wire pwm_on = {1'b0, cnt_ff} < ch_width_w[ch*9 +: 9];
      wire idle_on = {1'b0, cnt_ff} < ch_idle_width_w[ch*9 +: 9];
      assign nxt_pin[ch] = !buzz_force_on ? pwm_on :
                           (buzz_w == BUZZ_HIGH) ? 1'b1 :
                           (buzz_w == BUZZ_IDLE) ? idle_on : 1'b0;
    end
  endgenerate

  assign general_pin_seven_o = pin_ff[0];
  assign general_pin_six_o = pin_ff[1];
  assign general_pin_seven_oe_o = 1'b1;
  assign general_pin_six_oe_o = 1'b1;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_ff <= `CTRL_RESET;
      idle_ff <= `IDLE_RESET;
      map_ff <= `MAP_RESET;
      apb_state_ff <= APB_IDLE;
      prdata_ff <= 32'h00000000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      idle_ff <= nxt_idle;
      map_ff <= nxt_map;
      apb_state_ff <= nxt_apb_state;
      prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rep_idx_ff <= 3'h0;
      rep_valid_ff <= 1'b0;
      prev_touch_ff <= 8'h00;
      bus_status_ff <= 8'h00;
      idle_hold_ff <= 1'b0;
      buzz_seen_ff <= 1'b0;
      cnt_ff <= 8'h00;
      pin_ff <= 2'b00;
    end else begin
      rep_idx_ff <= nxt_rep_idx;
      rep_valid_ff <= nxt_rep_valid;
      prev_touch_ff <= nxt_prev_touch;
      bus_status_ff <= nxt_bus_status;
      idle_hold_ff <= nxt_idle_hold;
      buzz_seen_ff <= nxt_buzz_seen;
      cnt_ff <= nxt_cnt;
      pin_ff <= nxt_pin;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_scan_only_update: assert property (
    !scan_tick_i |=> $stable(rep_idx_ff) && $stable(rep_valid_ff))
    else $error("reported button changed outside scan");
  a_idle_no_touch: assert property (
    scan_tick_i && touch_i == 8'h00 && !buzzer_active_i
    ##1 !buzz_force_on |-> !rep_valid_ff &&
    ch_idx_w[7:0] == idle_ff[7:0])
    else $error("idle level not shown with no touch");
  a_all_status: assert property (
    scan_tick_i && mode_w == REPORT_ALL |=>
    bus_status_ff == $past(touch_i))
    else $error("all mode status mismatch");
  a_single_status: assert property (
    scan_tick_i && mode_w != REPORT_ALL |=> $onehot0(bus_status_ff))
    else $error("more than one button reported");
  a_first_keep: assert property (
    scan_tick_i && mode_w == REPORT_FIRST && rep_alive |=>
    rep_idx_ff == $past(rep_idx_ff))
    else $error("first mode dropped held button");
  a_first_lowest: assert property (
    scan_tick_i && mode_w == REPORT_FIRST && !rep_alive && any_touch |=>
    rep_idx_ff == pick_lowest($past(touch_i)))
    else $error("first mode did not pick lowest");
  a_strong_hold: assert property (
    scan_tick_i && mode_w == REPORT_STRONG && rep_alive && !upgrade_w |=>
    rep_idx_ff == $past(rep_idx_ff))
    else $error("weaker touch replaced strongest");
  a_buzz_low: assert property (
    buzzer_active_i && buzz_w == BUZZ_LOW |=> pin_ff == 2'b00)
    else $error("buzzer low force not applied");
  a_full_width: assert property (
    ch_width_w[8:0] == 9'h100 && !buzz_force_on |=> pin_ff[0] [*1])
    else $error("full width pulse not high");
  a_full_width_six: assert property (
    ch_width_w[17:9] == 9'h100 && !buzz_force_on |=> pin_ff[1])
    else $error("full width pulse not high on pin six");
  a_short_clamp: assert property (
    p64_w |-> ch_width_w[8:0] <= 9'h040 && ch_width_w[17:9] <= 9'h040)
    else $error("short period width above 64");
  a_hold_idle: assert property (
    idle_hold_ff |-> ch_idx_w[7:0] == idle_ff[7:0])
    else $error("idle hold not showing idle level");

  c_first_switch: cover property (
    scan_tick_i && mode_w == REPORT_FIRST && switched_w);
  c_strong_upgrade: cover property (
    scan_tick_i && mode_w == REPORT_STRONG && rep_alive && upgrade_w);
  c_buzz_force: cover property (buzz_force_on ##1 !buzz_force_on);
  c_idle_hold: cover property ($rose(idle_hold_ff));

endmodule

// *** host_adc_model.sv ***
`timescale 1ns/10ps
module host_adc_model (
  // clock
  input wire logic mclk_i,
  // level pin and the pwm period it uses
  input wire logic pin_i,
  input wire logic [8:0] period_i,
  // high count over the last full period, the filtered level
  output logic [8:0] width_o
);
  logic [8:0] cnt_ff = 9'h000;
  logic [8:0] acc_ff = 9'h000;

  initial width_o = 9'h000;

  // any window of one period holds exactly one pulse width
  always @(posedge mclk_i) begin
    if (cnt_ff >= period_i - 9'h001) begin
      width_o <= acc_ff + 9'(pin_i);
      acc_ff <= 9'h000;
      cnt_ff <= 9'h000;
    end else begin
      acc_ff <= acc_ff + 9'(pin_i);
      cnt_ff <= cnt_ff + 9'h001;
    end
  end
endmodule

// *** level_store.sv ***
`timescale 1ns/10ps
module level_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read ports, registered data
  input wire logic [AW-1:0] raddr_a_i,
  output logic [WIDTH-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [WIDTH-1:0] rdata_b_o
);

  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else begin
      rdata_a_o <= mem_ff[raddr_a_i];
      rdata_b_o <= mem_ff[raddr_b_i];
    end
  end

endmodule

// *** tb.sv ***
`timescale 1ns/10ps
`include "button_level_consts.svh"
module tb;
  import button_level_pkg::*;
  logic mclk_i, reset_i, psel, penable, pwrite, scan_tick, buzz;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pin7, oe7, pin6, oe6, err;
  logic [7:0] touch;
  logic [63:0] strength;
  logic [8:0] period, wa, wb;
  logic [8:0] buzz_a [4] = '{9'h000, 9'h000, 9'h100, 9'h021};
  logic [8:0] buzz_b [4] = '{9'h000, 9'h000, 9'h100, 9'h031};
  int failures, total_checks, cycles;

  button_level_pwm_reporter button_level_pwm_reporter_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .scan_tick_i(scan_tick), .touch_i(touch),
    .strength_i(strength), .buzzer_active_i(buzz),
    .general_pin_seven_o(pin7), .general_pin_seven_oe_o(oe7),
    .general_pin_six_o(pin6), .general_pin_six_oe_o(oe6));
  host_adc_model host_adc_model_i (.mclk_i(mclk_i), .pin_i(pin7),
    .period_i(period), .width_o(wa));
  host_adc_model host_adc_model_i2 (.mclk_i(mclk_i), .pin_i(pin6),
    .period_i(period), .width_o(wb));

  task give_verdict;
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task scan(input logic [7:0] t, input logic [63:0] s);
    @(posedge mclk_i);
    scan_tick <= 1'b1;
    touch <= t;
    strength <= s;
    @(posedge mclk_i);
    scan_tick <= 1'b0;
  endtask

  task stat(input logic [31:0] e);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status", e, rd);
  endtask

  // wait out the change, then one clean period per channel
  task pins(input logic [8:0] ea, input logic [8:0] eb);
    repeat (3 * period) @(posedge mclk_i);
    chk("width_a", 32'(ea), 32'(wa));
    chk("width_b", 32'(eb), 32'(wb));
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge mclk_i);
      cycles++;
      if (cycles > 60000) begin
        failures++;
        give_verdict;
      end
    end
  end

  initial begin
    {reset_i, psel, penable, pwrite, scan_tick, buzz} = 6'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    touch = 8'h00;
    strength = 64'h0;
    period = 9'h100;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, `OFS_MAP, 32'h0);
    chk("map", 32'h5555, rd);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    apb(1'b1, `OFS_LEVEL_BASE, 32'h10);
    apb(1'b1, `OFS_LEVEL_BASE + 12'h004, 32'hffffffff);
    apb(1'b1, `OFS_LEVEL_BASE + 12'h008, 32'h64);
    apb(1'b0, `OFS_LEVEL_BASE + 12'h004, 32'h0);
    chk("level1", 32'hff, rd);
    apb(1'b1, `OFS_IDLE, 32'h3020);
    apb(1'b1, `OFS_MAP, 32'h5579);
    chk("oe", 32'h3, 32'({oe7, oe6}));
    scan(8'h00, 64'h0);
    pins(9'h021, 9'h031);
    scan(8'h0a, 64'h0);
    stat(32'h1102);
    pins(9'h021, 9'h100);
    touch <= 8'h00;
    stat(32'h1102);
    scan(8'h0b, 64'h0);
    stat(32'h1102);
    scan(8'h09, 64'h0);
    stat(32'h1001);
    pins(9'h011, 9'h031);
    apb(1'b1, `OFS_CTRL, 32'h2);
    scan(8'h00, 64'h0);
    scan(8'h01, 64'h0000_0000_0014_320a);
    stat(32'h1001);
    scan(8'h03, 64'h0000_0000_0014_320a);
    stat(32'h1102);
    scan(8'h07, 64'h0000_0000_0014_320a);
    stat(32'h1102);
    scan(8'h06, 64'h0000_0000_0014_320a);
    stat(32'h1102);
    pins(9'h021, 9'h100);
    apb(1'b1, `OFS_CTRL, 32'h0);
    scan(8'h05, 64'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("bus_status", 32'h05, 32'(rd[7:0]));
    apb(1'b1, `OFS_CTRL, 32'h1);
    scan(8'h04, 64'h0);
    pins(9'h065, 9'h065);
    for (int f = 1; f < 4; f++) begin
      apb(1'b1, `OFS_CTRL, 32'h1 | 32'(f << 3));
      buzz <= 1'b1;
      pins(buzz_a[f], buzz_b[f]);
      buzz <= 1'b0;
    end
    pins(9'h065, 9'h065);
    apb(1'b1, `OFS_CTRL, 32'h29);
    buzz <= 1'b1;
    repeat (4) @(posedge mclk_i);
    buzz <= 1'b0;
    scan(8'h04, 64'h0);
    pins(9'h021, 9'h031);
    scan(8'h04, 64'h0);
    pins(9'h065, 9'h065);
    apb(1'b1, `OFS_CTRL, 32'h41);
    scan(8'h0c, 64'h0);
    scan(8'h08, 64'h0);
    stat(32'h3308);
    pins(9'h021, 9'h031);
    scan(8'h08, 64'h0);
    pins(9'h000, 9'h031);
    apb(1'b1, `OFS_CTRL, 32'h5);
    period <= 9'h040;
    scan(8'h01, 64'h0);
    pins(9'h011, 9'h031);
    scan(8'h04, 64'h0);
    pins(9'h040, 9'h040);
    give_verdict;
  end
endmodule
